// ==== src/scp_status_counters.sv ====
// mac-side pcs status and transmit counter register bank, page three
// assumes all inputs synchronous to clock; read data valid one cycle later
`timescale 1ns/1ps
`default_nettype none
module scp_status_counters (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // pcs and link state
    input wire scp_pkg::scpMacPcs_s macIn,
    input wire scp_pkg::scpTxEvents_s txEv,
    // control towards the pcs and egress path
    output scp_pkg::scpCtrl_s ctrlOut
);
    import scp_pkg::*;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [15:0] page_r;
    logic [15:0] ctrl_r;
    logic [15:0] adv_r;
    logic [15:0] partner_r;
    logic [3:0] statSticky_r;
    logic [1:0] commaSticky_r;
    logic commaDet_r;
    logic [3:0] commaPos_r;
    logic qsgmiiSync_r;
    logic [13:0] goodCnt_r;
    logic [7:0] crcCnt_r;
    logic [1:0] sel_r;
    logic fix_r;
    logic [15:0] rdData_nxt;
    logic [15:0] advTx_nxt;

    function automatic logic hit(input logic [4:0] a, input logic [15:0] pg,
                                 input logic [4:0] off);
        hit = (a == off) && (pg == PAGE_EXT3);
    endfunction

    logic rdStat;
    logic rdComma;
    logic wrCtrl;
    logic wrAdv;
    logic wrCrc;
    assign rdStat = regRd && hit(regAddr, page_r, OFF_STAT);
    assign rdComma = regRd && hit(regAddr, page_r, OFF_COMMA);
    assign wrCtrl = regWr && hit(regAddr, page_r, OFF_CTRL);
    assign wrAdv = regWr && hit(regAddr, page_r, OFF_ADV);
    assign wrCrc = regWr && hit(regAddr, page_r, OFF_CRC);

    // ----------------------------------------------------------------
    // page select and control
    // ----------------------------------------------------------------
    // page register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page_r <= 16'h0000;
        end else if (regWr && regAddr == OFF_PAGE) begin
            page_r <= regWrData;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_r <= regWrData & CTRL_WMASK;
        end else begin
            ctrl_r[CTRL_ANRESTART_BIT] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // advertised and partner ability
    // ----------------------------------------------------------------
    // guarded write
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            adv_r <= ADV_RESET;
        end else if (wrAdv && ctrl_r[CTRL_FORCE_BIT]) begin
            adv_r <= regWrData;
        end
    end

    always_comb begin
        advTx_nxt = macIn.localWord;
        if (ctrl_r[CTRL_FORCE_BIT]) begin
            advTx_nxt = adv_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            partner_r <= 16'h0000;
        end else if (macIn.partnerWordValid) begin
            partner_r <= macIn.partnerWord;
        end
    end

    // ----------------------------------------------------------------
    // since-last-read status bits
    // ----------------------------------------------------------------
    logic [3:0] statEvent;
    assign statEvent = {!macIn.syncOk, macIn.cgBad, macIn.alignErr,
                        macIn.partnerRestart};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_stat
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    statSticky_r[gi] <= 1'b0;
                end else if (statEvent[gi]) begin
                    statSticky_r[gi] <= 1'b1;
                end else if (rdStat) begin
                    statSticky_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // comma status
    // ----------------------------------------------------------------
    logic [1:0] commaEvent;
    assign commaEvent = {macIn.commaRealign, macIn.sigDetEvent};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_comma
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    commaSticky_r[gi] <= 1'b0;
                end else if (commaEvent[gi]) begin
                    commaSticky_r[gi] <= 1'b1;
                end else if (rdComma) begin
                    commaSticky_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            commaDet_r <= 1'b0;
        end else begin
            commaDet_r <= rdComma || macIn.commaSeen;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qsgmiiSync_r <= 1'b0;
            commaPos_r <= 4'h0;
        end else begin
            qsgmiiSync_r <= macIn.firstPort && macIn.qsgmiiSync;
            if (macIn.qsgmiiMode || macIn.commaPos > COMMA_POS_MAX) begin
                commaPos_r <= 4'h0;
            end else begin
                commaPos_r <= macIn.commaPos;
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit counters
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= SEL_MEDIA;
            fix_r <= 1'b0;
        end else if (wrCrc) begin
            sel_r <= regWrData[CRC_SEL_HI:CRC_SEL_LO];
            fix_r <= regWrData[CRC_FIX_BIT];
        end
    end

    logic goodEv;
    logic crcEv;
    always_comb begin
        goodEv = 1'b0;
        crcEv = 1'b0;
        unique case (sel_r)
            SEL_MEDIA: begin
                goodEv = txEv.mediaGood;
                crcEv = txEv.mediaCrcErr;
            end
            SEL_MAC: begin
                goodEv = txEv.macGood;
                crcEv = txEv.macCrcErr;
            end
            default: begin
                goodEv = 1'b0;
                crcEv = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            goodCnt_r <= 14'h0000;
        end else if (txEv.mediaLinkUp && goodEv) begin
            if (goodCnt_r == GOOD_LAST) begin
                goodCnt_r <= 14'h0000;
            end else begin
                goodCnt_r <= goodCnt_r + 14'h0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            crcCnt_r <= 8'h00;
        end else if (txEv.mediaLinkUp && crcEv && crcCnt_r != CRC_MAX) begin
            crcCnt_r <= crcCnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        rdData_nxt = 16'h0000;
        if (regAddr == OFF_PAGE) begin
            rdData_nxt = page_r;
        end else if (page_r == PAGE_EXT3) begin
            unique case (regAddr)
                OFF_CTRL: rdData_nxt = ctrl_r;
                OFF_STAT: rdData_nxt = {statSticky_r[3:2], 1'b0,
                    statSticky_r[1:0], 1'b0, macIn.remoteFault,
                    macIn.advAsymPause, macIn.advSymPause,
                    macIn.advFull, macIn.advHalf,
                    macIn.partnerAnCapable, macIn.linkUp,
                    macIn.anComplete, macIn.sigDetect};
                // value reflects the word on the wire
                OFF_ADV: rdData_nxt = advTx_nxt;
                OFF_PARTNER: rdData_nxt = partner_r;
                OFF_COMMA: rdData_nxt = {commaSticky_r, qsgmiiSync_r,
                    commaDet_r, commaPos_r, 8'h00};
                OFF_GOOD: rdData_nxt = {txEv.mediaLinkUp, 1'b0, goodCnt_r};
                OFF_CRC: rdData_nxt = {sel_r, fix_r, 5'h00, crcCnt_r};
                default: rdData_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            regRdData <= rdData_nxt;
        end else begin
            regRdData <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // control outputs
    // ----------------------------------------------------------------
    // registered control word to pcs and egress path
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrlOut <= '0;
        end else begin
            ctrlOut.advWord <= advTx_nxt;
            ctrlOut.forceAdv <= ctrl_r[CTRL_FORCE_BIT];
            ctrlOut.anRestart <= ctrl_r[CTRL_ANRESTART_BIT];
            ctrlOut.counterSel <= sel_r;
            ctrlOut.preambleFix <= fix_r;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sync_lost_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !macIn.syncOk |=> statSticky_r[3])
        else $error("sync loss not latched");

    sync_hold_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (statSticky_r[3] && !rdStat) |=> statSticky_r[3])
        else $error("sync loss bit dropped without read");

    read_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rdStat && macIn.syncOk) |=> !statSticky_r[3])
        else $error("sync loss bit not cleared by read");

    cgbad_latch_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        macIn.cgBad |=> statSticky_r[2])
        else $error("invalid code-group not latched");

    align_err_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        $rose(statSticky_r[1]) |-> $past(macIn.alignErr))
        else $error("alignment bit set without cause");

    restart_req_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (rdStat && !macIn.partnerRestart) |=> !statSticky_r[0])
        else $error("restart bit not cleared by read");

    adv_guard_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (wrAdv && !ctrl_r[CTRL_FORCE_BIT]) |=> $stable(adv_r))
        else $error("advertised word written without force");

    partner_cap_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        macIn.partnerWordValid |=> partner_r == $past(macIn.partnerWord))
        else $error("partner word not captured");

    comma_read_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        rdComma |=> commaDet_r)
        else $error("comma detect not set by read");

    realign_latch_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        macIn.commaRealign |=> commaSticky_r[1])
        else $error("comma realign not latched");

    sigdet_latch_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        macIn.sigDetEvent |=> commaSticky_r[0])
        else $error("signal detection not latched");

    comma_pos_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (!macIn.qsgmiiMode && macIn.commaPos <= COMMA_POS_MAX)
        |=> commaPos_r == $past(macIn.commaPos))
        else $error("comma position not reported");

    good_mod_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (goodCnt_r == GOOD_LAST && goodEv && txEv.mediaLinkUp)
        |=> goodCnt_r == 14'h0000)
        else $error("good count did not wrap at 10000");

    crc_sat_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        crcCnt_r == CRC_MAX |=> crcCnt_r == CRC_MAX)
        else $error("crc count left saturation");

    link_gate_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !txEv.mediaLinkUp |=> $stable(goodCnt_r) && $stable(crcCnt_r))
        else $error("counter moved with media link down");

    force_tx_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ctrl_r[CTRL_FORCE_BIT] |=> ctrlOut.advWord == $past(adv_r))
        else $error("forced word not transmitted");
endmodule
`default_nettype wire

// ==== src/scp_pkg.sv ====
// constants, carriers and register map of the mac-side pcs status block
// assumes one 125 MHz clock and a paged 5-bit register port
//
// Operation
// - status bit 15 latches sync loss until the status register is read
// - status bit 14 latches any invalid code-group until the next read
// - status bit 12 reports an sgmii alignment error
// - status bit 11 reports a partner request to restart negotiation
// - remote fault field 9:8 reads 00 without fault, nonzero with one
// - status bits 7:4 mirror asym pause, sym pause, full, half duplex
// - bits 3:0 show partner capable, link, negotiation done, signal
// - advertised word resets to zero, writable only while force bit set
// - partner ability holds the last code word received from the mac
// - comma status bit 15 latches a comma realign, cleared by read
// - comma status bit 14 latches signal detection, cleared by read
// - comma status bit 13 shows qsgmii sync, only on the first port
// - comma detect follows comma presence and a read sets it to one
// - bits 11:8 give comma position 0 to 9, undefined under qsgmii
// - good packet count is 14 bits modulo 10000, bit 15 shows active
// - selector 00 picks media counters, 01 mac, others reserved
// - preamble fix drops one byte only when preamble exceeds eight
// - crc error count is eight bits and saturates at 255
// - both transmit counters count only while the media link is up
// - force bit 11 sends the register word instead of internal word
package scp_pkg;
    localparam logic [4:0] OFF_CTRL = 5'h10;
    localparam logic [4:0] OFF_STAT = 5'h11;
    localparam logic [4:0] OFF_ADV = 5'h12;
    localparam logic [4:0] OFF_PARTNER = 5'h13;
    localparam logic [4:0] OFF_COMMA = 5'h14;
    localparam logic [4:0] OFF_GOOD = 5'h15;
    localparam logic [4:0] OFF_CRC = 5'h16;
    localparam logic [4:0] OFF_PAGE = 5'h1f;
    localparam logic [15:0] PAGE_EXT3 = 16'h0003;
    localparam logic [15:0] CTRL_RESET = 16'h0004;
    localparam logic [15:0] CTRL_WMASK = 16'hfffc;
    localparam int CTRL_FORCE_BIT = 11;
    localparam int CTRL_ANRESTART_BIT = 12;
    localparam int CRC_SEL_HI = 15;
    localparam int CRC_SEL_LO = 14;
    localparam int CRC_FIX_BIT = 13;
    localparam logic [1:0] SEL_MEDIA = 2'h0;
    localparam logic [1:0] SEL_MAC = 2'h1;
    localparam logic [13:0] GOOD_LAST = 14'h270f;
    localparam logic [7:0] CRC_MAX = 8'hff;
    localparam logic [3:0] COMMA_POS_MAX = 4'h9;
    localparam logic [15:0] ADV_RESET = 16'h0000;

    typedef struct packed {
        logic syncOk;
        logic cgBad;
        logic alignErr;
        logic partnerRestart;
        logic [1:0] remoteFault;
        logic advAsymPause;
        logic advSymPause;
        logic advFull;
        logic advHalf;
        logic partnerAnCapable;
        logic linkUp;
        logic anComplete;
        logic sigDetect;
        logic partnerWordValid;
        logic [15:0] partnerWord;
        logic [15:0] localWord;
        logic commaRealign;
        logic sigDetEvent;
        logic qsgmiiSync;
        logic commaSeen;
        logic [3:0] commaPos;
        logic qsgmiiMode;
        logic firstPort;
    } scpMacPcs_s;

    typedef struct packed {
        logic mediaLinkUp;
        logic mediaGood;
        logic mediaCrcErr;
        logic macGood;
        logic macCrcErr;
    } scpTxEvents_s;

    typedef struct packed {
        logic [15:0] advWord;
        logic forceAdv;
        logic anRestart;
        logic [1:0] counterSel;
        logic preambleFix;
    } scpCtrl_s;
endpackage

// ==== bench/scp_mac_partner.sv ====
// mac-side link partner and egress event source for the status bank
// assumes the bench hands it a fresh random word every cycle
`timescale 1ns/1ps
`default_nettype none
module scp_mac_partner (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // stimulus
    input wire logic run,
    input wire logic burst,
    input wire logic [31:0] rnd,
    // towards the block
    output scp_pkg::scpMacPcs_s macIn,
    output scp_pkg::scpTxEvents_s txEv
);
    import scp_pkg::*;
    // pulses last one cycle, levels wander
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            macIn <= '0;
            txEv <= '0;
        end else begin
            macIn.syncOk <= !(run && rnd[2:0] == 3'h7);
            macIn.cgBad <= run & rnd[3] & rnd[4];
            macIn.alignErr <= run & rnd[5] & rnd[6];
            macIn.partnerRestart <= run & rnd[7] & rnd[8];
            macIn.partnerWordValid <= run & rnd[9];
            macIn.partnerWord <= rnd[31:16];
            macIn.commaRealign <= run & rnd[10] & rnd[11];
            macIn.sigDetEvent <= run & rnd[12] & rnd[13];
            macIn.commaSeen <= run & rnd[15];
            if (run && rnd[14]) begin
                {macIn.remoteFault, macIn.advAsymPause, macIn.advSymPause,
                    macIn.advFull, macIn.advHalf, macIn.partnerAnCapable,
                    macIn.linkUp, macIn.anComplete, macIn.sigDetect,
                    macIn.qsgmiiSync, macIn.qsgmiiMode,
                    macIn.firstPort} <= rnd[27:15];
                macIn.commaPos <= rnd[31:28];
                macIn.localWord <= rnd[31:16];
            end
            txEv.mediaLinkUp <= burst | (run & rnd[27]);
            txEv.mediaGood <= burst | (run & rnd[1]);
            txEv.mediaCrcErr <= burst | (run & rnd[2] & rnd[0]);
            txEv.macGood <= burst | (run & rnd[20]);
            txEv.macCrcErr <= burst | (run & rnd[21] & rnd[22]);
        end
    end
endmodule
`default_nettype wire

// ==== bench/scp_status_counters_tb.sv ====
// self-checking bench of the mac-side status and counter bank
// assumes the partner model drives the pcs and egress event inputs
`timescale 1ns/1ps
`default_nettype none
module scp_status_counters_tb;
    import scp_pkg::*;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] regAddr = '0;
    logic [15:0] regWrData = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic run = 1'b0;
    logic burst = 1'b0;
    // seed 19454
    logic [31:0] rnd = 32'h0000_4bfe;
    logic [31:0] k;
    logic [15:0] regRdData;
    scpMacPcs_s macIn;
    scpTxEvents_s txEv;
    scpCtrl_s ctrlOut;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [3:0] sk;
    logic [1:0] cm;
    logic cdet, hitQ, rdS, rdC, gEv, cEv, fix;
    logic [4:0] aQ, ctrlE, cq;
    logic [15:0] ctrl, adv, part, page, expRd, advE;
    logic [1:0] sel;
    int good, crc;

    scp_status_counters i_dut (.clock(clock), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .macIn(macIn), .txEv(txEv),
        .ctrlOut(ctrlOut));
    scp_mac_partner i_partner (.clock(clock), .rst_n(rst_n), .run(run),
        .burst(burst), .rnd(rnd), .macIn(macIn), .txEv(txEv));

    always #4 clock = ~clock;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    always @(posedge clock) rnd <= lfsr(rnd);

    // ----------------------------------------
    // reference model
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sk = '0;
            cm = '0;
            cdet = 1'b0;
            aQ = 5'h00;
            ctrl = CTRL_RESET;
            adv = ADV_RESET;
            part = '0;
            page = '0;
            sel = SEL_MEDIA;
            fix = 1'b0;
            good = 0;
            crc = 0;
            expRd = '0;
            ctrlE = '0;
            cq = '0;
            advE = '0;
        end else begin
            hitQ = page == PAGE_EXT3;
            ctrlE = {ctrl[CTRL_FORCE_BIT], ctrl[CTRL_ANRESTART_BIT], sel, fix};
            advE = ctrl[CTRL_FORCE_BIT] ? adv : macIn.localWord;
            aQ = (regRd && (hitQ || regAddr == OFF_PAGE)) ? regAddr : 5'h00;
            case (aQ)
                OFF_PAGE: expRd = page;
                OFF_CTRL: expRd = ctrl;
                OFF_STAT: expRd = {sk[3:2], 1'b0, sk[1:0], 1'b0,
                    macIn.remoteFault, macIn.advAsymPause, macIn.advSymPause,
                    macIn.advFull, macIn.advHalf, macIn.partnerAnCapable,
                    macIn.linkUp, macIn.anComplete, macIn.sigDetect};
                OFF_ADV: expRd = advE;
                OFF_PARTNER: expRd = part;
                OFF_COMMA: expRd = {cm, cq[4], cdet, cq[3:0], 8'h00};
                OFF_GOOD: expRd = {txEv.mediaLinkUp, 1'b0, 14'(good)};
                OFF_CRC: expRd = {sel, fix, 5'h00, 8'(crc)};
                default: expRd = '0;
            endcase
            rdS = aQ == OFF_STAT;
            rdC = aQ == OFF_COMMA;
            sk = (sk & {4{!rdS}}) | {!macIn.syncOk, macIn.cgBad,
                macIn.alignErr, macIn.partnerRestart};
            cm = (cm & {2{!rdC}}) | {macIn.commaRealign, macIn.sigDetEvent};
            cdet = rdC | macIn.commaSeen;
            cq = {macIn.qsgmiiSync & macIn.firstPort, (macIn.qsgmiiMode
                || macIn.commaPos > COMMA_POS_MAX) ? 4'h0 : macIn.commaPos};
            if (macIn.partnerWordValid) part = macIn.partnerWord;
            gEv = sel == SEL_MEDIA ? txEv.mediaGood
                : sel == SEL_MAC && txEv.macGood;
            cEv = sel == SEL_MEDIA ? txEv.mediaCrcErr
                : sel == SEL_MAC && txEv.macCrcErr;
            if (txEv.mediaLinkUp && gEv) good = (good + 1) % 10000;
            if (txEv.mediaLinkUp && cEv && crc < 255) crc++;
            ctrl[CTRL_ANRESTART_BIT] = 1'b0;
            if (regWr && regAddr == OFF_PAGE) page = regWrData;
            if (regWr && hitQ) begin
                case (regAddr)
                    OFF_CTRL: ctrl = regWrData & CTRL_WMASK;
                    OFF_ADV: if (ctrl[CTRL_FORCE_BIT]) adv = regWrData;
                    OFF_CRC: {sel, fix} = regWrData[15:13];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // comparison
    // ----------------------------------------
    task automatic cmp(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk(input string nm, input logic [15:0] m);
        cmp(nm, expRd & m, regRdData & m);
    endtask

    always @(negedge clock) begin
        if (rst_n) begin
            case (aQ)
                OFF_STAT: begin
                    chk("sticky", 16'hd800);
                    chk("live", 16'h27ff);
                end
                OFF_ADV: chk("adv", 16'hffff);
                OFF_PARTNER: chk("partner", 16'hffff);
                OFF_COMMA: begin
                    chk("comma sticky", 16'hc000);
                    chk("comma live", 16'h3fff);
                end
                OFF_GOOD: chk("good", 16'hffff);
                OFF_CRC: chk("crc", 16'hffff);
                default: chk("other", 16'hffff);
            endcase
            cmp("ctrl", 16'(ctrlE), 16'(ctrlOut[4:0]));
            cmp("advWord", advE, ctrlOut.advWord);
        end
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    task automatic op(input logic w, input logic r, input logic [4:0] a,
            input logic [15:0] d);
        @(posedge clock);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            $display("CHECK FAILED run expected finish seen hang");
            conclude();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 16; a < 24; a++) op(1'b0, 1'b1, 5'(a), '0);
        op(1'b1, 1'b0, OFF_PAGE, PAGE_EXT3);
        op(1'b0, 1'b1, OFF_PAGE, '0);
        for (int a = 16; a < 24; a++) op(1'b0, 1'b1, 5'(a), '0);
        $display("test reset done");
        op(1'b1, 1'b0, OFF_ADV, 16'h1234);
        op(1'b0, 1'b1, OFF_ADV, '0);
        op(1'b1, 1'b0, OFF_CTRL, 16'h1800);
        op(1'b0, 1'b1, OFF_CTRL, '0);
        op(1'b1, 1'b0, OFF_ADV, 16'hbeef);
        op(1'b0, 1'b1, OFF_ADV, '0);
        repeat (3) @(posedge clock);
        @(negedge clock);
        cmp("advWord", 16'hbeef, ctrlOut.advWord);
        $display("test force done");
        run <= 1'b1;
        repeat (2500) begin
            k = rnd;
            if (k[2:0] < 3'h5) op(1'b0, 1'b1, 5'h10 + 5'(k[5:3]), '0);
            else if (k[2:0] == 3'h5)
                op(1'b1, 1'b0, OFF_CRC, {1'b0, k[7:6], 13'h0});
            else if (k[2:0] == 3'h6) op(1'b1, 1'b0, OFF_CTRL, k[31:16]);
            else if (k[8])
                op(1'b1, 1'b0, OFF_PAGE, {14'h0, k[9], k[9]});
            else op(1'b1, 1'b0, OFF_ADV, k[31:16]);
        end
        $display("test random done");
        run <= 1'b0;
        burst <= 1'b1;
        op(1'b1, 1'b0, OFF_PAGE, PAGE_EXT3);
        op(1'b1, 1'b0, OFF_CRC, 16'h4000);
        repeat (10050) @(posedge clock);
        op(1'b0, 1'b1, OFF_GOOD, '0);
        op(1'b0, 1'b1, OFF_CRC, '0);
        $display("test counters done");
        conclude();
    end
endmodule
`default_nettype wire
